// ==== scs_enable_seq.sv ====
// Operation
// - cleared tx enable holds transmitter in reset
// - cleared rx enable aborts reception immediately
// - tx starts at pointer once descriptor ready
// - rx starts at pointer if descriptor empty
// - init tx command restores reset tx state
// - init rx command restores reset rx state
// - combined init resets tx and rx together
// - parameter memory writable without full disable
// - one command resets whole processor
// - both enables cleared gates channel power
// - channel actions never change other channels' state, but init and halt stall all command and memory access
module scs_enable_seq #(
    parameter int NCH = 4
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire scs_pkg::scs_apb_req_t apb_req, // apb request group
    output scs_pkg::scs_apb_rsp_t apb_rsp, // apb answer group
    input wire logic [NCH-1:0] tx_desc_ready, // tx descriptor at pointer is ready
    input wire logic [NCH-1:0] tx_desc_done, // tx descriptor finished, pulse
    input wire logic [NCH-1:0] rx_desc_empty, // rx descriptor at pointer is empty
    input wire logic [NCH-1:0] rx_desc_done, // rx descriptor closed, pulse
    output logic [NCH-1:0] tx_active, // transmitter running
    output logic [NCH-1:0] rx_active, // receiver running
    output logic [NCH-1:0] tx_hold_rst, // transmitter held in reset
    output logic [NCH-1:0] rx_hold_rst, // receiver held in reset
    output logic [NCH-1:0] ch_clk_en, // channel clock gate enable
    output logic [NCH*scs_pkg::PTR_W-1:0] tx_desc_ptr, // tx descriptor pointers
    output logic [NCH*scs_pkg::PTR_W-1:0] rx_desc_ptr, // rx descriptor pointers
    output logic cmd_busy // command in progress
);

    localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;
    localparam int MAW = CHW + scs_pkg::WORDS_LOG;
    localparam logic [11:0] CH_END = scs_pkg::CH_BASE + 12'(NCH * 16);
    localparam logic [11:0] MEM_END = scs_pkg::MEM_BASE + 12'(NCH * 32);

    typedef struct packed {
        scs_pkg::scs_chan_t [NCH-1:0] ch;
        scs_pkg::scs_seq_t st;
        logic [CHW-1:0] cch;
        logic [MAW-1:0] clr_addr;
        logic [MAW-1:0] clr_last;
        scs_pkg::scs_apb_rsp_t rsp;
        logic [NCH-1:0] tx_rst;
        logic [NCH-1:0] rx_rst;
        logic [NCH-1:0] clk_en;
        logic busy;
    } scs_state_t;

    scs_state_t s_ff;
    scs_state_t nxt_s;
    logic mem_we;
    logic [MAW-1:0] mem_wa;
    logic [scs_pkg::MEM_DW-1:0] mem_wd;
    logic [MAW-1:0] mem_ra;
    logic [scs_pkg::MEM_DW-1:0] mem_rd;

    // ****************************************************************
    // address decoding
    // ****************************************************************
    function automatic scs_pkg::scs_region_t region_of(input logic [11:0] a);
        if (a == scs_pkg::CMD_OFS) begin
            region_of = scs_pkg::RG_CMD;
        end else if (a >= scs_pkg::CH_BASE && a < CH_END) begin
            region_of = scs_pkg::RG_CH;
        end else if (a >= scs_pkg::MEM_BASE && a < MEM_END) begin
            region_of = scs_pkg::RG_MEM;
        end else begin
            region_of = scs_pkg::RG_NONE;
        end
    endfunction

    function automatic logic [CHW-1:0] chan_of(input logic [11:0] a);
        logic [11:0] d;
        d = a - scs_pkg::CH_BASE;
        chan_of = CHW'(d >> 4);
    endfunction

    function automatic logic [MAW-1:0] word_of(input logic [11:0] a);
        logic [11:0] d;
        d = a - scs_pkg::MEM_BASE;
        word_of = MAW'(d >> 2);
    endfunction

    function automatic logic [31:0] chan_read(input scs_pkg::scs_chan_t c, input logic [3:0] r);
        chan_read = '0;
        case (r)
            scs_pkg::MODE_OFS: begin
                chan_read[scs_pkg::MODE_TXEN_POS] = c.tx_en;
                chan_read[scs_pkg::MODE_RXEN_POS] = c.rx_en;
                chan_read[scs_pkg::MODE_PROTO_POS +: 4] = c.proto;
                chan_read[scs_pkg::MODE_RCLK_POS] = c.rclk_en;
            end
            scs_pkg::TXP_OFS: chan_read[scs_pkg::PTR_W-1:0] = c.tx_ptr;
            scs_pkg::RXP_OFS: chan_read[scs_pkg::PTR_W-1:0] = c.rx_ptr;
            scs_pkg::STAT_OFS: begin
                chan_read[7:0] = {c.rx_resync, c.tx_halted, c.tx_stopped, c.rx_act, c.tx_act,
                    !(c.tx_en || c.rx_en), !c.rx_en, !c.tx_en};
            end
            default: chan_read = '0;
        endcase
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic acc;
        logic stall;
        logic [CHW-1:0] c;
        logic [CHW-1:0] k;
        scs_pkg::scs_region_t rg;
        nxt_s = s_ff;
        acc = apb_req.psel && apb_req.penable && s_ff.rsp.pready;
        rg = region_of(apb_req.paddr);
        stall = 1'b0;
        c = chan_of(apb_req.paddr);
        k = CHW'(apb_req.pwdata[scs_pkg::CMD_CH_POS +: 2]);
        mem_we = 1'b0;
        mem_wa = '0;
        mem_wd = '0;
        mem_ra = word_of(apb_req.paddr);
        nxt_s.rsp.pready = 1'b0;
        nxt_s.rsp.pslverr = 1'b0;

        // each channel runs from its own state only
        for (int i = 0; i < NCH; i++) begin
            if (!s_ff.ch[i].tx_en) begin
                nxt_s.ch[i].tx_act = 1'b0;
            end else if (s_ff.ch[i].tx_act) begin
                if (tx_desc_done[i]) begin
                    nxt_s.ch[i].tx_act = 1'b0;
                    nxt_s.ch[i].tx_ptr = scs_pkg::PTR_W'(s_ff.ch[i].tx_ptr + 1'b1);
                end
            end else if (tx_desc_ready[i] && !s_ff.ch[i].tx_halt_pend && !s_ff.ch[i].tx_stopped
                && !s_ff.ch[i].tx_halted) begin
                nxt_s.ch[i].tx_act = 1'b1;
            end
            // halt completes once idle, also on a disabled transmitter
            if (s_ff.ch[i].tx_halt_pend && !s_ff.ch[i].tx_act) begin
                nxt_s.ch[i].tx_halt_pend = 1'b0;
                nxt_s.ch[i].tx_halted = 1'b1;
            end
            if (!s_ff.ch[i].rx_en) begin
                nxt_s.ch[i].rx_act = 1'b0;
            end else if (s_ff.ch[i].rx_act) begin
                if (rx_desc_done[i]) begin
                    nxt_s.ch[i].rx_act = 1'b0;
                    nxt_s.ch[i].rx_ptr = scs_pkg::PTR_W'(s_ff.ch[i].rx_ptr + 1'b1);
                end
            end else if (rx_desc_empty[i]) begin
                nxt_s.ch[i].rx_act = 1'b1;
                nxt_s.ch[i].rx_resync = 1'b0;
            end
        end

        // register writes
        if (acc && apb_req.pwrite && rg == scs_pkg::RG_CH) begin
            case (apb_req.paddr[3:0])
                scs_pkg::MODE_OFS: begin
                    nxt_s.ch[c].tx_en = apb_req.pwdata[scs_pkg::MODE_TXEN_POS];
                    nxt_s.ch[c].rx_en = apb_req.pwdata[scs_pkg::MODE_RXEN_POS];
                    nxt_s.ch[c].proto = apb_req.pwdata[scs_pkg::MODE_PROTO_POS +: 4];
                    nxt_s.ch[c].rclk_en = apb_req.pwdata[scs_pkg::MODE_RCLK_POS];
                    if (!apb_req.pwdata[scs_pkg::MODE_TXEN_POS]) begin
                        nxt_s.ch[c].tx_act = 1'b0;
                    end
                    if (!apb_req.pwdata[scs_pkg::MODE_RXEN_POS]) begin
                        nxt_s.ch[c].rx_act = 1'b0;
                    end
                end
                scs_pkg::TXP_OFS: nxt_s.ch[c].tx_ptr = apb_req.pwdata[scs_pkg::PTR_W-1:0];
                scs_pkg::RXP_OFS: nxt_s.ch[c].rx_ptr = apb_req.pwdata[scs_pkg::PTR_W-1:0];
                default: nxt_s.ch[c].tx_ptr = nxt_s.ch[c].tx_ptr;
            endcase
        end
        if (acc && apb_req.pwrite && rg == scs_pkg::RG_MEM) begin
            mem_we = 1'b1;
            mem_wa = word_of(apb_req.paddr);
            mem_wd = apb_req.pwdata[scs_pkg::MEM_DW-1:0];
        end

        // command sequencer
        case (s_ff.st)
            scs_pkg::SQ_IDLE: begin
                if (acc && apb_req.pwrite && rg == scs_pkg::RG_CMD) begin
                    nxt_s.cch = k;
                    case (apb_req.pwdata[scs_pkg::CMD_OP_POS +: 4])
                        scs_pkg::OP_INIT_TX: begin
                            nxt_s.ch[k].tx_act = 1'b0;
                            nxt_s.ch[k].tx_stopped = 1'b0;
                            nxt_s.ch[k].tx_halt_pend = 1'b0;
                            nxt_s.ch[k].tx_halted = 1'b0;
                            nxt_s.ch[k].tx_ptr = scs_pkg::TX_PTR_RST;
                            nxt_s.clr_addr = {k, scs_pkg::TX_FIRST};
                            nxt_s.clr_last = {k, scs_pkg::TX_LAST};
                            nxt_s.st = scs_pkg::SQ_CLEAR;
                        end
                        scs_pkg::OP_INIT_RX: begin
                            nxt_s.ch[k].rx_act = 1'b0;
                            nxt_s.ch[k].rx_resync = 1'b0;
                            nxt_s.ch[k].rx_ptr = scs_pkg::RX_PTR_RST;
                            nxt_s.clr_addr = {k, scs_pkg::RX_FIRST};
                            nxt_s.clr_last = {k, scs_pkg::RX_LAST};
                            nxt_s.st = scs_pkg::SQ_CLEAR;
                        end
                        scs_pkg::OP_INIT_ALL: begin
                            nxt_s.ch[k] = scs_pkg::CHAN_RST;
                            nxt_s.ch[k].tx_en = s_ff.ch[k].tx_en;
                            nxt_s.ch[k].rx_en = s_ff.ch[k].rx_en;
                            nxt_s.ch[k].proto = s_ff.ch[k].proto;
                            nxt_s.ch[k].rclk_en = s_ff.ch[k].rclk_en;
                            nxt_s.clr_addr = {k, scs_pkg::TX_FIRST};
                            nxt_s.clr_last = {k, scs_pkg::RX_LAST};
                            nxt_s.st = scs_pkg::SQ_CLEAR;
                        end
                        scs_pkg::OP_RX_RESYNC: begin
                            nxt_s.ch[k].rx_act = 1'b0;
                            nxt_s.ch[k].rx_resync = 1'b1;
                        end
                        scs_pkg::OP_STOP_TX: begin
                            nxt_s.ch[k].tx_act = 1'b0;
                            nxt_s.ch[k].tx_stopped = 1'b1;
                        end
                        scs_pkg::OP_HALT_TX: begin
                            nxt_s.ch[k].tx_halt_pend = 1'b1;
                            nxt_s.st = scs_pkg::SQ_HALT;
                        end
                        scs_pkg::OP_RESTART_TX: begin
                            nxt_s.ch[k].tx_stopped = 1'b0;
                            nxt_s.ch[k].tx_halted = 1'b0;
                            nxt_s.ch[k].tx_halt_pend = 1'b0;
                        end
                        scs_pkg::OP_RESET_ALL: begin
                            for (int i = 0; i < NCH; i++) begin
                                nxt_s.ch[i] = scs_pkg::CHAN_RST;
                            end
                            nxt_s.clr_addr = '0;
                            nxt_s.clr_last = '1;
                            nxt_s.st = scs_pkg::SQ_CLEAR;
                        end
                        default: nxt_s.st = scs_pkg::SQ_IDLE;
                    endcase
                end
            end
            scs_pkg::SQ_CLEAR: begin
                mem_we = 1'b1;
                mem_wa = s_ff.clr_addr;
                mem_wd = '0;
                if (s_ff.clr_addr == s_ff.clr_last) begin
                    nxt_s.st = scs_pkg::SQ_IDLE;
                end else begin
                    nxt_s.clr_addr = MAW'(s_ff.clr_addr + 1'b1);
                end
            end
            scs_pkg::SQ_HALT: begin
                if (s_ff.ch[s_ff.cch].tx_halted || !s_ff.ch[s_ff.cch].tx_halt_pend) begin
                    nxt_s.st = scs_pkg::SQ_IDLE;
                end
            end
            default: nxt_s.st = scs_pkg::SQ_IDLE;
        endcase

        // apb answer, commands and memory wait while busy
        stall = (s_ff.st != scs_pkg::SQ_IDLE) && (rg == scs_pkg::RG_CMD || rg == scs_pkg::RG_MEM);
        if (apb_req.psel && apb_req.penable && !s_ff.rsp.pready && !stall) begin
            nxt_s.rsp.pready = 1'b1;
            nxt_s.rsp.prdata = '0;
            case (rg)
                scs_pkg::RG_CMD: nxt_s.rsp.prdata[scs_pkg::CMD_BUSY_POS] = s_ff.busy;
                scs_pkg::RG_CH: nxt_s.rsp.prdata = chan_read(s_ff.ch[c], apb_req.paddr[3:0]);
                scs_pkg::RG_MEM: nxt_s.rsp.prdata[scs_pkg::MEM_DW-1:0] = mem_rd;
                default: nxt_s.rsp.pslverr = 1'b1;
            endcase
        end

        for (int i = 0; i < NCH; i++) begin
            nxt_s.tx_rst[i] = !nxt_s.ch[i].tx_en;
            nxt_s.rx_rst[i] = !nxt_s.ch[i].rx_en;
            nxt_s.clk_en[i] = nxt_s.ch[i].tx_en || nxt_s.ch[i].rx_en;
        end
        nxt_s.busy = (nxt_s.st != scs_pkg::SQ_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '{ch: {NCH{scs_pkg::CHAN_RST}}, st: scs_pkg::SQ_IDLE, cch: '0, clr_addr: '0,
                clr_last: '0, rsp: '0, tx_rst: '1, rx_rst: '1, clk_en: '0, busy: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************************************
    // parameter memory and outputs
    // ****************************************************************
    scs_param_mem #(
        .AW(MAW),
        .DW(scs_pkg::MEM_DW)
    ) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(mem_we),
        .waddr(mem_wa),
        .wdata(mem_wd),
        .raddr(mem_ra),
        .rdata_ff(mem_rd)
    );

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_out
            assign tx_active[g] = s_ff.ch[g].tx_act;
            assign rx_active[g] = s_ff.ch[g].rx_act;
            assign tx_desc_ptr[g*scs_pkg::PTR_W +: scs_pkg::PTR_W] = s_ff.ch[g].tx_ptr;
            assign rx_desc_ptr[g*scs_pkg::PTR_W +: scs_pkg::PTR_W] = s_ff.ch[g].rx_ptr;
        end
    endgenerate

    assign tx_hold_rst = s_ff.tx_rst;
    assign rx_hold_rst = s_ff.rx_rst;
    assign ch_clk_en = s_ff.clk_en;
    assign cmd_busy = s_ff.busy;
    assign apb_rsp = s_ff.rsp;

endmodule // scs_enable_seq

// ==== scs_enable_seq_props.sv ====
module scs_enable_seq_props #(
    parameter int NCH = 4
) (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire scs_pkg::scs_apb_req_t apb_req, // apb request
    input wire scs_pkg::scs_apb_rsp_t apb_rsp, // apb answer
    input wire logic [NCH-1:0] tx_desc_ready, // tx descriptor ready
    input wire logic [NCH-1:0] tx_desc_done, // tx descriptor done
    input wire logic [NCH-1:0] rx_desc_empty, // rx descriptor empty
    input wire logic [NCH-1:0] rx_desc_done, // rx descriptor done
    input wire logic [NCH-1:0] tx_active, // tx running
    input wire logic [NCH-1:0] rx_active, // rx running
    input wire logic [NCH-1:0] tx_hold_rst, // tx held
    input wire logic [NCH-1:0] rx_hold_rst, // rx held
    input wire logic [NCH-1:0] ch_clk_en, // clock gate
    input wire logic [NCH*scs_pkg::PTR_W-1:0] tx_desc_ptr, // tx pointers
    input wire logic [NCH*scs_pkg::PTR_W-1:0] rx_desc_ptr, // rx pointers
    input wire logic cmd_busy // command busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic cmd_take = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
        && apb_req.paddr == scs_pkg::CMD_OFS;
    tx_held_idle_a: assert property ((tx_hold_rst & tx_active) == '0)
        else $error("tx active while held");
    rx_held_idle_a: assert property ((rx_hold_rst & rx_active) == '0)
        else $error("rx active while held");
    power_gate_a: assert property (ch_clk_en == ~(tx_hold_rst & rx_hold_rst))
        else $error("clock gate wrong");
    tx_start_a: assert property ($rose(tx_active[0]) |-> $past(tx_desc_ready[0]) && !$past(tx_hold_rst[0]))
        else $error("tx started without cause");
    rx_start_a: assert property ($rose(rx_active[0]) |-> $past(rx_desc_empty[0]) && !$past(rx_hold_rst[0]))
        else $error("rx started without cause");
    tx_done_a: assert property (tx_active[0] && tx_desc_done[0] |=>
        !tx_active[0] && tx_desc_ptr[15:0] == $past(tx_desc_ptr[15:0]) + 16'h1) else $error("tx done wrong");
    cmd_stall_a: assert property (apb_rsp.pready && apb_req.psel && apb_req.paddr == scs_pkg::CMD_OFS
        |-> !$past(cmd_busy)) else $error("command access not stalled");
    init_tx_a: assert property (cmd_take && apb_req.pwdata[3:0] == 4'h1 |=> cmd_busy[*4] ##1 !cmd_busy)
        else $error("init tx busy length");
    init_rx_a: assert property (cmd_take && apb_req.pwdata[3:0] == 4'h2 |=> cmd_busy[*4] ##1 !cmd_busy)
        else $error("init rx busy length");
    init_all_a: assert property (cmd_take && apb_req.pwdata[3:0] == 4'h0 |=> cmd_busy[*8] ##1 !cmd_busy)
        else $error("init all busy length");
    reset_all_a: assert property (cmd_take && apb_req.pwdata[3:0] == 4'h8
        |-> ##[1:2] (&tx_hold_rst && &rx_hold_rst && ch_clk_en == '0)) else $error("reset all incomplete");
endmodule // scs_enable_seq_props

bind scs_enable_seq scs_enable_seq_props #(.NCH(NCH)) u_props (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .tx_desc_ready(tx_desc_ready), .tx_desc_done(tx_desc_done),
    .rx_desc_empty(rx_desc_empty), .rx_desc_done(rx_desc_done), .tx_active(tx_active), .rx_active(rx_active),
    .tx_hold_rst(tx_hold_rst), .rx_hold_rst(rx_hold_rst), .ch_clk_en(ch_clk_en), .tx_desc_ptr(tx_desc_ptr),
    .rx_desc_ptr(rx_desc_ptr), .cmd_busy(cmd_busy));

// ==== scs_param_mem.sv ====
module scs_param_mem #(
    parameter int AW = 5,
    parameter int DW = 16
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic we, // write strobe
    input wire logic [AW-1:0] waddr, // write address
    input wire logic [DW-1:0] wdata, // write data
    input wire logic [AW-1:0] raddr, // read address
    output logic [DW-1:0] rdata_ff // registered read data
);

    logic [DW-1:0] mem [2**AW];

    // ****************************************************************
    // storage, no reset on the array
    // ****************************************************************
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= mem[raddr];
        end
    end

endmodule // scs_param_mem

// ==== scs_pkg.sv ====
package scs_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] CMD_OFS = 12'h000;
    localparam logic [11:0] CH_BASE = 12'h040;
    localparam logic [11:0] CH_STRIDE = 12'h010;
    localparam logic [3:0] MODE_OFS = 4'h0;
    localparam logic [3:0] TXP_OFS = 4'h4;
    localparam logic [3:0] RXP_OFS = 4'h8;
    localparam logic [3:0] STAT_OFS = 4'hc;
    localparam logic [11:0] MEM_BASE = 12'h200;
    localparam logic [11:0] MEM_STRIDE = 12'h020;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int MODE_TXEN_POS = 0;
    localparam int MODE_RXEN_POS = 1;
    localparam int MODE_PROTO_POS = 4;
    localparam int MODE_RCLK_POS = 8;
    localparam int CMD_OP_POS = 0;
    localparam int CMD_CH_POS = 8;
    localparam int CMD_BUSY_POS = 31;

    // ****************************************************************
    // sizes and reset values
    // ****************************************************************
    localparam int PTR_W = 16;
    localparam int MEM_DW = 16;
    localparam int WORDS_LOG = 3;
    localparam logic [2:0] TX_FIRST = 3'h0;
    localparam logic [2:0] TX_LAST = 3'h3;
    localparam logic [2:0] RX_FIRST = 3'h4;
    localparam logic [2:0] RX_LAST = 3'h7;
    localparam logic [15:0] TX_PTR_RST = 16'h0000;
    localparam logic [15:0] RX_PTR_RST = 16'h0000;
    localparam logic [3:0] PROTO_RST = 4'h0;

    typedef enum logic [3:0] {
        OP_INIT_ALL = 4'h0,
        OP_INIT_TX = 4'h1,
        OP_INIT_RX = 4'h2,
        OP_RX_RESYNC = 4'h3,
        OP_STOP_TX = 4'h4,
        OP_HALT_TX = 4'h5,
        OP_RESTART_TX = 4'h6,
        OP_RESET_ALL = 4'h8
    } scs_op_t;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'h0,
        SQ_CLEAR = 2'h1,
        SQ_HALT = 2'h2
    } scs_seq_t;

    typedef enum logic [1:0] {
        RG_CMD = 2'h0,
        RG_CH = 2'h1,
        RG_MEM = 2'h2,
        RG_NONE = 2'h3
    } scs_region_t;

    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic [3:0] proto;
        logic rclk_en;
        logic tx_act;
        logic rx_act;
        logic tx_stopped;
        logic tx_halt_pend;
        logic tx_halted;
        logic rx_resync;
        logic [PTR_W-1:0] tx_ptr;
        logic [PTR_W-1:0] rx_ptr;
    } scs_chan_t;

    localparam scs_chan_t CHAN_RST = '{tx_en: 1'b0, rx_en: 1'b0, proto: PROTO_RST, rclk_en: 1'b0,
        tx_act: 1'b0, rx_act: 1'b0, tx_stopped: 1'b0, tx_halt_pend: 1'b0, tx_halted: 1'b0,
        rx_resync: 1'b0, tx_ptr: TX_PTR_RST, rx_ptr: RX_PTR_RST};

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } scs_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } scs_apb_rsp_t;

endpackage

// ==== testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] CMD = scs_pkg::CMD_OFS;
    localparam logic [11:0] MEM = scs_pkg::MEM_BASE;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    scs_pkg::scs_apb_req_t req = '0;
    scs_pkg::scs_apb_rsp_t rsp;
    logic [3:0] trdy = '0, tdone = '0, rempty = '0, rdone = '0;
    logic [3:0] tx_act, rx_act, tx_rst, rx_rst, clk_en;
    logic [63:0] tptr, rptr;
    logic busy, rerr;
    logic [31:0] rdata;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    always #20 pclk = ~pclk;

    scs_enable_seq #(.NCH(4)) uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .tx_desc_ready(trdy), .tx_desc_done(tdone), .rx_desc_empty(rempty), .rx_desc_done(rdone),
        .tx_active(tx_act), .rx_active(rx_act), .tx_hold_rst(tx_rst), .rx_hold_rst(rx_rst),
        .ch_clk_en(clk_en), .tx_desc_ptr(tptr), .rx_desc_ptr(rptr), .cmd_busy(busy));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compares %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        // pready is sampled at the rising edge; the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rdata = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    function automatic logic [11:0] ra(input logic [1:0] ch, input logic [3:0] ofs);
        return scs_pkg::CH_BASE + scs_pkg::CH_STRIDE * {10'h000, ch} + {8'h00, ofs};
    endfunction

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({28'h0, tx_rst}, 32'hf);
        chk({28'h0, clk_en}, 32'h0);
        apb(1'b0, ra(2'h0, scs_pkg::STAT_OFS), 32'h0);
        chk(rdata, 32'h7);
        apb(1'b0, 12'hffc, 32'h0);
        chk({rerr, rdata[30:0]}, 32'h80000000);
        $display("reset test done");
        @(posedge pclk);
        trdy <= 4'h3;
        apb(1'b1, ra(2'h1, scs_pkg::MODE_OFS), 32'h1);
        apb(1'b1, ra(2'h0, scs_pkg::MODE_OFS), 32'h1);
        repeat (2) @(negedge pclk);
        chk({28'h0, tx_act}, 32'h3);
        chk({28'h0, tx_rst}, 32'hc);
        @(posedge pclk);
        trdy <= 4'h2;
        tdone <= 4'h1;
        @(posedge pclk);
        tdone <= 4'h0;
        @(negedge pclk);
        chk({28'h0, tx_act}, 32'h2);
        chk({16'h0, tptr[15:0]}, 32'h1);
        $display("tx test done");
        apb(1'b1, ra(2'h0, scs_pkg::RXP_OFS), 32'h10);
        @(posedge pclk);
        rempty <= 4'h1;
        apb(1'b1, ra(2'h0, scs_pkg::MODE_OFS), 32'h3);
        repeat (2) @(negedge pclk);
        chk({28'h0, rx_act}, 32'h1);
        chk({16'h0, rptr[15:0]}, 32'h10);
        @(posedge pclk);
        rdone <= 4'h1;
        @(posedge pclk);
        rdone <= 4'h0;
        @(negedge pclk);
        chk({28'h0, rx_act}, 32'h0);
        chk({16'h0, rptr[15:0]}, 32'h11);
        apb(1'b1, ra(2'h0, scs_pkg::MODE_OFS), 32'h1);
        @(negedge pclk);
        chk({28'h0, rx_act, rx_rst}, 32'h0f);
        chk({28'h0, tx_act}, 32'h2);
        $display("rx test done");
        @(posedge pclk);
        trdy <= 4'h3;
        repeat (2) @(negedge pclk);
        chk({28'h0, tx_act}, 32'h3);
        apb(1'b1, CMD, 32'h004);
        @(negedge pclk);
        chk({28'h0, tx_act}, 32'h2);
        apb(1'b1, CMD, 32'h006);
        repeat (2) @(negedge pclk);
        chk({28'h0, tx_act}, 32'h3);
        apb(1'b1, CMD, 32'h205);
        apb(1'b0, ra(2'h2, scs_pkg::STAT_OFS), 32'h0);
        chk(rdata, 32'h47);
        apb(1'b1, CMD, 32'h003);
        apb(1'b0, ra(2'h0, scs_pkg::STAT_OFS), 32'h0);
        chk(rdata & 32'h80, 32'h80);
        $display("command test done");
        apb(1'b1, MEM, 32'hbeef);
        apb(1'b0, MEM, 32'h0);
        chk(rdata, 32'hbeef);
        apb(1'b1, ra(2'h0, scs_pkg::MODE_OFS), 32'h0);
        apb(1'b1, CMD, 32'h001);
        @(negedge pclk);
        chk({31'h0, busy}, 32'h1);
        apb(1'b0, MEM, 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, ra(2'h0, scs_pkg::TXP_OFS), 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, ra(2'h0, scs_pkg::RXP_OFS), 32'h0);
        chk(rdata, 32'h11);
        @(negedge pclk);
        chk({28'h0, tx_act}, 32'h2);
        apb(1'b1, MEM + 12'h010, 32'h1234);
        apb(1'b1, CMD, 32'h002);
        apb(1'b0, MEM + 12'h010, 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, ra(2'h0, scs_pkg::RXP_OFS), 32'h0);
        chk(rdata, 32'h0);
        apb(1'b1, ra(2'h0, scs_pkg::RXP_OFS), 32'h22);
        apb(1'b1, MEM + 12'h010, 32'h55);
        apb(1'b1, CMD, 32'h000);
        apb(1'b0, MEM + 12'h010, 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, ra(2'h0, scs_pkg::RXP_OFS), 32'h0);
        chk(rdata, 32'h0);
        apb(1'b1, ra(2'h0, scs_pkg::MODE_OFS), 32'h153);
        apb(1'b0, ra(2'h0, scs_pkg::MODE_OFS), 32'h0);
        chk(rdata, 32'h153);
        $display("init test done");
        apb(1'b1, CMD, 32'h008);
        apb(1'b0, MEM, 32'h0);
        chk(rdata, 32'h0);
        @(negedge pclk);
        chk({28'h0, tx_rst}, 32'hf);
        chk({28'h0, clk_en}, 32'h0);
        apb(1'b0, ra(2'h0, scs_pkg::MODE_OFS), 32'h0);
        chk(rdata, 32'h0);
        $display("reset all test done");
        summarize();
    end
endmodule // testbench
